// ### src/bfr_pkg.sv
// constants, field layout and state encoding of the burst flash read control
// assumes a single core clock and a byte-addressed request side
package bfr_pkg;
    localparam int          REG_AW         = 8;
    localparam logic [7:0]  MODE_OFS       = 8'h00;
    localparam logic [7:0]  STAT_OFS       = 8'h04;
    localparam logic [31:0] MODE_RESET     = 32'h0000_0000;
    localparam logic [31:0] MODE_WMASK     = 32'h000f_37ff;
    localparam int          COM_LSB        = 0;
    localparam int          CC_LSB         = 2;
    localparam int          AVL_LSB        = 4;
    localparam int          PAGES_LSB      = 8;
    localparam int          OEL_LSB        = 12;
    localparam int          ADV_EN_BIT     = 16;
    localparam int          RESUME_BIT     = 17;
    localparam int          SHARED_BIT     = 18;
    localparam int          RDY_EN_BIT     = 19;
    localparam logic [1:0]  MODE_OFF       = 2'h0;
    localparam logic [1:0]  MODE_ASYNC     = 2'h1;
    localparam logic [1:0]  MODE_BURST     = 2'h2;
    localparam logic [1:0]  CLK_DIV1       = 2'h1;
    localparam logic [1:0]  CLK_DIV2       = 2'h2;
    localparam logic [2:0]  PER_M1_DIV1    = 3'h0;
    localparam logic [2:0]  PER_M1_DIV2    = 3'h1;
    localparam logic [2:0]  PER_M1_DIV4    = 3'h3;
    localparam logic [2:0]  PAGES_OFF      = 3'h0;
    localparam int          PAGE_BASE      = 8;
    localparam int          HALF_BYTES     = 2;
    localparam logic [1:0]  OEL_MIN        = 2'h1;
    typedef enum logic [2:0] {
        ST_IDLE, ST_LATCH, ST_SAMPLE, ST_OPEN, ST_ADV, ST_RESUME, ST_SUSP
    } bfr_state_t;
endpackage

// ### src/bfr_tick_if.sv
// burst clock timing carried from the divider to the sequencer
// assumes both ends run on core_clk
`timescale 1ns/1ps
`default_nettype none
interface bfr_tick_if;
    logic tick;
    logic high;
    modport src (output tick, output high);
    modport snk (input tick, input high);
endinterface
`default_nettype wire

// ### src/bfr_clkdiv.sv
// burst clock divider: one tick per burst clock rising edge, but one tick every core cycle at divide by one
// assumes clock_select is stable while a burst runs
`timescale 1ns/1ps
`default_nettype none
module bfr_clkdiv
    import bfr_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic [1:0] clock_select,
    bfr_tick_if.src         ck
);
    logic [2:0] cnt;
    logic       tgl;
    wire  [2:0] per_m1;

    // reserved code falls back to the slowest rate, never faster than programmed
    assign per_m1 = (clock_select == CLK_DIV1) ? PER_M1_DIV1 :
                    (clock_select == CLK_DIV2) ? PER_M1_DIV2 : PER_M1_DIV4;
    assign ck.tick = (cnt == 3'h0);
    assign ck.high = (per_m1 == PER_M1_DIV1) ? tgl : (cnt <= (per_m1 >> 1));

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cnt <= 3'h0;
            tgl <= 1'b0;
        end else begin
            cnt <= (cnt >= per_m1) ? 3'h0 : cnt + 3'h1;
            tgl <= ~tgl;
        end
    end
endmodule
`default_nettype wire

// ### src/bfr_burst_read.sv
// burst read sequencer with its mode register and pin drivers
// assumes requests are halfword reads at byte addresses, pins synchronous to core_clk
//
// Behaviour
// - resume mode: suspend on deselect, resume sequential access after output-enable latency.
// - no resume mode: any access after deselection starts a new burst.
// - page handling on: a page-boundary address restarts the burst.
// - page field 0 disables; 1..7 select 16 to 1024 byte pages.
// - ready handling on: low ready holds off sampling until ready returns.
// - ready enable clear: ready input ignored, only latencies time data.
// - mode field: 00 off, 01 asynchronous, 10 burst read, 11 reserved; only 10 is decoded here, 01 leaves the block idle.
// - clock field: 01 master, 10 half, 11 quarter; 00 reserved; at 01 the pin clock runs at half core rate, the same as 10.
// - sample edge is latency field plus one edges after address valid.
// - output-enable latency idle cycles follow each output-enable change.
// - advance by gated clock pulses, or by strobe with a free clock.
// - shared bus on: address also driven on data bus during address valid.
`timescale 1ns/1ps
`default_nettype none
module bfr_burst_read
    import bfr_pkg::*;
#(
    parameter int ADDR_W = 25,
    parameter int DATA_W = 16
) (
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic [REG_AW-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    input  wire logic              flash_select,
    input  wire logic              rd_req,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic                   rd_ready,
    output logic                   rd_done,
    output logic      [DATA_W-1:0] rd_data,
    output logic                   burst_clock_out,
    output logic                   address_valid_out,
    output logic                   flash_output_enable,
    output logic                   address_advance_strobe,
    output logic      [ADDR_W-1:0] flash_addr,
    output logic      [DATA_W-1:0] flash_data_out,
    output logic                   flash_data_oe_b,
    input  wire logic [DATA_W-1:0] flash_data_in,
    input  wire logic              flash_ready_in
);
    bfr_tick_if ck ();

    logic [31:0]       mode_cfg;
    bfr_state_t        state;
    bfr_state_t        next_state;
    logic [4:0]        lat_cnt;
    logic [4:0]        next_lat_cnt;
    logic [1:0]        oel_cnt;
    logic              burst_open;
    logic              next_burst_open;
    logic              oe;
    logic              next_oe;
    logic              avd;
    logic              next_avd;
    logic              strobe;
    logic              next_strobe;
    logic              rdy_q;
    logic [ADDR_W-1:0] cur_addr;
    logic [ADDR_W-1:0] next_cur_addr;
    logic [ADDR_W-1:0] exp_addr;
    logic              done_q;
    logic              take_data;
    logic              take_q;

    wire [1:0]        op_mode     = mode_cfg[COM_LSB +: 2];
    wire [1:0]        clk_sel     = mode_cfg[CC_LSB +: 2];
    wire [3:0]        address_valid_latency         = mode_cfg[AVL_LSB +: 4];
    wire [2:0]        pages       = mode_cfg[PAGES_LSB +: 3];
    wire [1:0]        oel_raw     = mode_cfg[OEL_LSB +: 2];
    wire              adv_en      = mode_cfg[ADV_EN_BIT];
    wire              resume_mode = mode_cfg[RESUME_BIT];
    wire              shared_bus  = mode_cfg[SHARED_BIT];
    wire              rdy_en      = mode_cfg[RDY_EN_BIT];
    // code 11 decodes to neither async nor burst, so the block stays idle
    wire              burst_mode  = (op_mode == MODE_BURST);
    wire              tick        = ck.tick;
    // a zero latency would let the bus turn round too early
    wire [1:0]        output_enable_latency         = (oel_raw < OEL_MIN) ? OEL_MIN : oel_raw;
    wire [4:0]        avl_w       = {1'b0, address_valid_latency};
    wire [ADDR_W-1:0] page_mask   = ADDR_W'((PAGE_BASE << pages) - 1);
    wire              page_edge   = (pages != PAGES_OFF) && ((rd_addr & page_mask) == '0);
    wire              sequential  = burst_open && (rd_addr == exp_addr) && !page_edge;
    wire              idle_like   = (state == ST_IDLE) || (state == ST_OPEN) || (state == ST_SUSP);
    wire              take        = rd_req && rd_ready;
    // ready seen on the previous burst edge announces data on this one
    wire              data_ok     = !rdy_en || rdy_q;
    wire              clk_gate    = (state == ST_LATCH) || (state == ST_SAMPLE);
    // strobe mode keeps the clock free; gated mode only clocks when the flash must move
    wire              clk_run     = burst_mode && (adv_en || clk_gate);
    wire              mode_hit    = (reg_addr == MODE_OFS);
    wire              stat_hit    = (reg_addr == STAT_OFS);
    wire [31:0]       stat_word   = {26'h0, state, oel_cnt != 2'h0, oe, burst_open};
    wire [31:0]       rd_word     = mode_hit ? mode_cfg : (stat_hit ? stat_word : 32'h0);

    assign rd_ready = burst_mode && flash_select && idle_like && (oel_cnt == 2'h0);
    assign rd_done  = done_q;

    bfr_clkdiv u_div (
        .core_clk     (core_clk),
        .rst_b        (rst_b),
        .clock_select (clk_sel),
        .ck           (ck)
    );

    always_comb begin
        next_state      = state;
        next_lat_cnt    = lat_cnt;
        next_burst_open = burst_open;
        next_oe         = oe;
        next_avd        = avd;
        next_strobe     = strobe;
        next_cur_addr   = cur_addr;
        take_data       = 1'b0;
        case (state)
            ST_IDLE, ST_OPEN, ST_SUSP: begin
                if (!burst_mode) begin
                    next_state      = ST_IDLE;
                    next_oe         = 1'b0;
                    next_burst_open = 1'b0;
                end else if (take) begin
                    next_cur_addr = rd_addr;
                    if (sequential && state == ST_OPEN) begin
                        next_state = ST_ADV;
                    end else if (sequential && state == ST_SUSP && resume_mode) begin
                        next_state = ST_RESUME;
                        next_oe    = 1'b1;
                    end else begin
                        // any other access breaks the burst and latches anew
                        next_state      = ST_LATCH;
                        next_burst_open = 1'b0;
                        next_oe         = 1'b0;
                        next_lat_cnt    = 5'h0;
                    end
                end else if (state == ST_OPEN && !flash_select) begin
                    next_state      = ST_SUSP;
                    next_oe         = 1'b0;
                    next_burst_open = resume_mode;
                end
            end
            ST_LATCH: begin
                if (tick && !avd && lat_cnt == 5'h0 && oel_cnt == 2'h0) begin
                    next_avd = 1'b1;
                end else if (tick && avd) begin
                    // first edge with address valid seen: release it and open the output
                    next_avd     = 1'b0;
                    next_oe      = 1'b1;
                    next_lat_cnt = 5'h1;
                    if (avl_w == 5'h0) begin
                        next_state = ST_SAMPLE;
                    end
                end else if (tick && lat_cnt != 5'h0) begin
                    next_lat_cnt = lat_cnt + 5'h1;
                    if (lat_cnt == avl_w) begin
                        next_state = ST_SAMPLE;
                    end
                end
            end
            ST_ADV: begin
                if (tick) begin
                    next_strobe = adv_en;
                    next_state  = ST_SAMPLE;
                end
            end
            ST_RESUME: begin
                if (tick && oel_cnt == 2'h0) begin
                    next_state = ST_ADV;
                end
            end
            ST_SAMPLE: begin
                if (tick) begin
                    next_strobe = 1'b0;
                    if (data_ok) begin
                        take_data       = 1'b1;
                        next_state      = ST_OPEN;
                        next_burst_open = 1'b1;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_oe    = 1'b0;
                next_avd   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state      <= ST_IDLE;
            lat_cnt    <= 5'h0;
            burst_open <= 1'b0;
            oe         <= 1'b0;
            avd        <= 1'b0;
            strobe     <= 1'b0;
            cur_addr   <= '0;
        end else begin
            state      <= next_state;
            lat_cnt    <= next_lat_cnt;
            burst_open <= next_burst_open;
            oe         <= next_oe;
            avd        <= next_avd;
            strobe     <= next_strobe;
            cur_addr   <= next_cur_addr;
        end
    end

    // idle burst cycles after every output-enable edge
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            oel_cnt <= 2'h0;
        end else if (next_oe != oe) begin
            oel_cnt <= output_enable_latency;
        end else if (tick && oel_cnt != 2'h0) begin
            oel_cnt <= oel_cnt - 2'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rdy_q <= 1'b0;
        end else if (tick) begin
            rdy_q <= flash_ready_in;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rd_data  <= '0;
            done_q   <= 1'b0;
            take_q   <= 1'b0;
            exp_addr <= '0;
        end else begin
            // pins trail the sequencer by a cycle, so data is taken one cycle after the sample tick
            take_q <= take_data;
            done_q <= take_q;
            if (take_q) begin
                rd_data <= flash_data_in;
            end
            if (take_data) begin
                exp_addr <= cur_addr + ADDR_W'(HALF_BYTES);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            mode_cfg  <= MODE_RESET;
            reg_rdata <= 32'h0;
        end else begin
            if (reg_wr && mode_hit) begin
                mode_cfg <= reg_wdata & MODE_WMASK;
            end
            reg_rdata <= reg_rd ? rd_word : 32'h0;
        end
    end

    // pins are registered, so they trail the internal tick by one core cycle
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            burst_clock_out        <= 1'b0;
            address_valid_out      <= 1'b0;
            flash_output_enable    <= 1'b0;
            address_advance_strobe <= 1'b0;
            flash_addr             <= '0;
            flash_data_out         <= '0;
            flash_data_oe_b        <= 1'b1;
        end else begin
            burst_clock_out        <= clk_run && ck.high;
            address_valid_out      <= avd;
            flash_output_enable    <= oe;
            address_advance_strobe <= strobe;
            flash_addr             <= cur_addr;
            flash_data_out         <= DATA_W'(cur_addr);
            flash_data_oe_b        <= !(avd && shared_bus);
        end
    end
endmodule
`default_nettype wire

// ### sim/bfr_burst_read_sva.sv
// checker on the top ports of the burst read sequencer
// assumes bound to every bfr_burst_read, one clock domain
`timescale 1ns/1ps
`default_nettype none
module bfr_burst_read_sva
    import bfr_pkg::*;
#(
    parameter int ADDR_W = 25,
    parameter int DATA_W = 16
) (
    input wire logic              core_clk,
    input wire logic              rst_b,
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    input wire logic              flash_select,
    input wire logic              rd_ready,
    input wire logic              rd_done,
    input wire logic              address_valid_out,
    input wire logic              flash_output_enable,
    input wire logic              address_advance_strobe,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic [DATA_W-1:0] flash_data_out,
    input wire logic              flash_data_oe_b
);
    logic [31:0] mode;
    logic [7:0]  since_avd;
    logic        fresh;
    wire         quiet = mode[3:2] == CLK_DIV1 && !mode[RDY_EN_BIT];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // shadow mode word; cycles counted from the rise of address valid
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            mode      <= MODE_RESET;
            since_avd <= 8'h00;
            fresh     <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == MODE_OFS) mode <= reg_wdata & MODE_WMASK;
            if ($rose(address_valid_out)) begin
                since_avd <= 8'h01;
                fresh     <= 1'b1;
            end else begin
                since_avd <= since_avd + {7'h0, since_avd != 8'hff};
                fresh     <= fresh && !rd_done;
            end
        end
    end
    mode_read_a: assert property (reg_rd && reg_addr == MODE_OFS |=> reg_rdata == $past(mode))
        else $error("mode readback differs");
    not_burst_a: assert property (mode[1:0] != MODE_BURST |-> !rd_ready)
        else $error("request open outside burst mode");
    avl_count_a: assert property (rd_done && fresh && quiet |-> since_avd == {4'h0, mode[7:4]} + 8'h02)
        else $error("fresh burst sampled on wrong edge");
    no_strobe_a: assert property (!mode[ADV_EN_BIT] |-> !address_advance_strobe)
        else $error("strobe in gated clock mode");
    shared_drive_a: assert property (!flash_data_oe_b |-> mode[SHARED_BIT] && address_valid_out
        && flash_data_out == flash_addr[DATA_W-1:0])
        else $error("data pins driven wrongly");
    shared_all_a: assert property ($rose(address_valid_out) && mode[SHARED_BIT] |-> !flash_data_oe_b)
        else $error("address missing on data pins");
    deselect_oe_a: assert property ($fell(flash_select) && flash_output_enable |-> ##[1:2] !flash_output_enable)
        else $error("output enable kept after deselect");
    oe_idle_a: assert property ($fell(flash_output_enable) |-> !address_valid_out [*2])
        else $error("no idle after output enable change");
    cover property (rd_done && fresh);
    cover property ($rose(address_advance_strobe));
    cover property ($fell(flash_output_enable) ##[1:20] $rose(flash_output_enable));
endmodule
bind bfr_burst_read bfr_burst_read_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_sva (.*);
`default_nettype wire

// ### sim/bfr_flash_model.sv
// behavioural burst flash: pointer loads on address valid, steps on strobe
// assumes pins synchronous to core_clk; gated advance is not modelled
`timescale 1ns/1ps
`default_nettype none
module bfr_flash_model #(
    parameter int ADDR_W = 25,
    parameter int DATA_W = 16
) (
    input  wire logic              core_clk,
    input  wire logic              address_valid_out,
    input  wire logic              flash_output_enable,
    input  wire logic              address_advance_strobe,
    input  wire logic [ADDR_W-1:0] flash_addr,
    input  wire logic              stall,
    output logic      [DATA_W-1:0] flash_data_in,
    output logic                   flash_ready_in
);
    logic [ADDR_W-1:0] ptr = '0;
    logic [DATA_W-1:0] last = '0;
    always @(posedge core_clk) begin
        if (address_valid_out) ptr <= flash_addr;
        else if (address_advance_strobe) ptr <= ptr + ADDR_W'(2);
        last <= flash_data_in;
    end
    // released bus toggles so a late sample cannot match
    // the strobe edge already shows the advanced word
    assign flash_data_in = flash_output_enable ?
                           (ptr[DATA_W-1:0] + (address_advance_strobe ? DATA_W'(2) : DATA_W'(0))) ^ DATA_W'(16'ha5c3)
                           : ~last;
    // ready only drops on bench request; data is already valid when it rises
    assign flash_ready_in = !stall;
endmodule
`default_nettype wire

// ### sim/bfr_burst_read_tb.sv
// self-checking bench: register port, burst reads against the flash model
// assumes 10 MHz core clock; status register checked only once, right after reset
`timescale 1ns/1ps
`default_nettype none
module bfr_burst_read_tb
    import bfr_pkg::*;
;
    logic              core_clk = 1'b0;
    logic              rst_b = 1'b0;
    logic [7:0]        reg_addr = '0;
    logic [31:0]       reg_wdata = '0;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic              flash_select = 1'b1;
    logic              rd_req = 1'b0;
    logic [24:0]       rd_addr = '0;
    logic              stall = 1'b0;
    logic [31:0]       reg_rdata;
    logic              rd_ready, rd_done, burst_clock_out, address_valid_out;
    logic              flash_output_enable, address_advance_strobe, flash_data_oe_b, flash_ready_in;
    logic [15:0]       rd_data, flash_data_out, flash_data_in;
    logic [24:0]       flash_addr;
    logic [31:0]       rq[$];
    logic [15:0]       dq[$];
    logic [1:0]        ops[3] = '{2'h0, 2'h1, 2'h3};
    int                fail_count = 0, checks_done = 0, bursts = 0, cyc = 0, t, seed;
    logic              rd_pend = 1'b0, bq;
    logic [31:0]       wd;
    bfr_burst_read dut (.*);
    bfr_flash_model u_flash (.*);
    always #50 core_clk = ~core_clk;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // result monitor: reg data one cycle after the strobe, read data on done
    always @(posedge core_clk) begin
        cyc++;
        if (rd_pend) chk("reg_rdata", rq.pop_front(), reg_rdata);
        if (rd_done) chk("rd_data", dq.size() != 0 ? {16'h0, dq[0]} : 32'hx, {16'h0, rd_data});
        if (rd_done && dq.size() != 0) void'(dq.pop_front());
        if ($rose(address_valid_out)) bursts++;
        rd_pend = reg_rd;
        if (cyc == 30000) begin
            fail_count++;
            conclude();
        end
    end
    function automatic logic [31:0] md(input logic [3:0] f, input logic [1:0] output_enable_latency, input logic [2:0] pg,
                                       input logic [3:0] address_valid_latency, input logic [1:0] cc);
        return {12'h0, f, 2'h0, output_enable_latency, 1'b0, pg, address_valid_latency, cc, MODE_BURST};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rr(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        rq.push_back(e);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask
    // one halfword read; nb is the count of new bursts expected, -1 to skip
    task automatic rd(input logic [24:0] a, input int nb);
        int n = 0;
        int b = bursts;
        @(posedge core_clk);
        dq.push_back(a[15:0] ^ 16'ha5c3);
        rd_req  <= 1'b1;
        rd_addr <= a;
        do @(posedge core_clk); while (!rd_ready && ++n < 300);
        rd_req <= 1'b0;
        while (dq.size() != 0 && n < 600) begin
            @(posedge core_clk);
            n++;
        end
        chk("pending", 0, 32'(dq.size()));
        dq.delete();
        if (nb >= 0) chk("bursts", 32'(nb), 32'(bursts - b));
    endtask
    initial begin
        seed = $urandom(45);
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        rr(MODE_OFS, MODE_RESET);
        rr(STAT_OFS, 32'h0);
        wd = $urandom;
        wr(MODE_OFS, wd);
        rr(MODE_OFS, wd & MODE_WMASK);
        wr(STAT_OFS, 32'hffff_ffff);
        rr(MODE_OFS, wd & MODE_WMASK);
        rr(8'h08, 32'h0);
        foreach (ops[i]) begin
            wr(MODE_OFS, {30'h0, ops[i]} | 32'h0000_0014);
            repeat (4) @(posedge core_clk);
            chk("rd_ready", 0, {31'h0, rd_ready});
        end
        for (int i = 0; i < 6; i++) begin
            wr(MODE_OFS, md(4'h1, 2'h1, PAGES_OFF, 4'($urandom_range(7)), CLK_DIV1));
            rd({9'h0, 16'($urandom)} & 25'h1fffe, 1);
        end
        // free clock in strobe mode: 16 toggles per 16 core cycles at codes 01 and 10, 8 at code 11
        for (int c = 1; c < 4; c++) begin
            wr(MODE_OFS, md(4'h1, 2'h1, PAGES_OFF, 4'h1, 2'(c)));
            repeat (8) @(posedge core_clk);
            t = 0;
            repeat (16) begin
                bq = burst_clock_out;
                @(posedge core_clk);
                t += int'(burst_clock_out !== bq);
            end
            chk("bclk_toggles", 32'((c == 1) ? 16 : (32 >> (c - 1))), 32'(t));
            rd(25'h400 + 25'(c * 64), 1);
        end
        for (int r = 1; r >= 0; r--) begin
            wr(MODE_OFS, md({2'h0, r[0], 1'b1}, 2'h2, PAGES_OFF, 4'h2, CLK_DIV1));
            rd(25'h1000, 1);
            rd(25'h1002, 0);
            flash_select <= 1'b0;
            repeat (6) @(posedge core_clk);
            chk("oe_suspend", 0, {31'h0, flash_output_enable});
            flash_select <= 1'b1;
            rd(25'h1004, 1 - r);
        end
        for (int p = 0; p < 8; p++) begin
            wr(MODE_OFS, md(4'h1, 2'h1, 3'(p), 4'h1, CLK_DIV1));
            rd(25'h8000 + 25'((4 << p) - 2), -1);
            rd(25'h8000 + 25'(4 << p), 0);
            rd(25'h8000 + 25'((8 << p) - 2), -1);
            rd(25'h8000 + 25'(8 << p), (p != 0) ? 1 : 0);
        end
        wr(MODE_OFS, md(4'h9, 2'h1, PAGES_OFF, 4'h1, CLK_DIV1));
        stall <= 1'b1;
        fork
            rd(25'h2000, 1);
            begin
                repeat (30) @(posedge core_clk);
                chk("stalled", 1, 32'(dq.size()));
                stall <= 1'b0;
            end
        join
        wr(MODE_OFS, md(4'h1, 2'h1, PAGES_OFF, 4'h1, CLK_DIV1));
        stall <= 1'b1;
        rd(25'h2100, 1);
        stall <= 1'b0;
        // gated advance with shared pins: only fresh bursts, the model has no gated stepping
        wr(MODE_OFS, md(4'h4, 2'h3, PAGES_OFF, 4'h3, CLK_DIV2));
        rd(25'h3000, 1);
        rd(25'h3100, 1);
        repeat (5) @(posedge core_clk);
        conclude();
    end
endmodule
`default_nettype wire
